// ==== hdl/adsq_calib.sv ====
`timescale 1ns/10ps
`include "adsq_regs.svh"

module adsq_calib #(
    parameter int CAL_CYCLES = `ADSQ_CAL_CPU_CYC
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // calibration status
    output logic      calBusy,
    output logic      calEn
);
    import adsq_pkg::*;

    localparam logic [`ADSQ_CAL_CNT_W-1:0] CAL_LAST =
        `ADSQ_CAL_CNT_W'(CAL_CYCLES - 1);

    adsq_cal_s_t q;
    adsq_cal_s_t d;

    // runs once per reset; nothing else can restart it, no recal needed
    always_comb begin
        d = q;
        if (q.busy) begin
            if (q.cnt == CAL_LAST) begin
                d.busy = 1'b0;
            end else begin
                d.cnt = q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '{cnt: '0, busy: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign calBusy = q.busy;
    assign calEn   = q.busy;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    cal_length_a: assert property (q.busy |-> q.cnt <= CAL_LAST)
        else $error("calibration ran past its length");
endmodule

// ==== hdl/adsq_ctrl.sv ====
`timescale 1ns/10ps
`include "adsq_regs.svh"
// Operation
// - 10-bit results from 16+8 channels
// - one bit picks the port group
// - programmable sample and conversion times
// - unread result overwritten raises overrun pulse
// - protect mode suspends start until read
// - single channel single: one conversion
// - single channel continuous: repeat same channel
// - scan single: each channel once, in turn
// - scan continuous: cycle channels until a stop request
// - every stored result gives a transfer event
// - wait-for-read in continuous modes buffers result, holds conversion
// - injected conversion, continuous mode then resumes
// - injected result goes to injection register
// - self-calibration after reset, bounded length
// - busy during calibration, no conversion then
// - no recalibration during normal running
// - unused analog pins stay digital inputs

module adsq_ctrl #(
    parameter int CAL_CYCLES = `ADSQ_CAL_CPU_CYC
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // control bits
    input  wire adsq_pkg::adsq_mode_t   mode,
    input  wire logic                   portSel,
    input  wire logic [`ADSQ_CH_W-1:0]  startChannel,
    input  wire logic [`ADSQ_TIME_W-1:0] sampleTime,
    input  wire logic [`ADSQ_TIME_W-1:0] convTime,
    input  wire logic                   overrunProtect,
    input  wire logic                   waitForReadEnable,
    input  wire logic                   startReq,
    input  wire logic                   stopReq,
    input  wire logic                   injectReq,
    input  wire logic [`ADSQ_CH_W-1:0]  injectChannel,
    // conversion result register side
    input  wire logic                   resultRead,
    output logic      [`ADSQ_RES_W-1:0] resultValue,
    output logic      [`ADSQ_CH_W-1:0]  resultChannel,
    output logic                        resultValid,
    output logic                        resultEvent,
    output logic                        overrunIrq,
    // injection result register side
    output logic      [`ADSQ_RES_W-1:0] injResultValue,
    output logic                        injEvent,
    // status
    output logic                        busyFlag,
    // analog multiplexer and conversion core
    output logic      [`ADSQ_CH_W-1:0]  muxChannel,
    output logic                        muxPortSel,
    output logic                        sampleEn,
    output logic                        convEn,
    output logic                        calEn,
    input  wire logic [`ADSQ_RES_W-1:0] coreData,
    // port pins as digital inputs
    input  wire logic [`ADSQ_PIN_W-1:0] pinIn,
    output logic      [`ADSQ_PIN_W-1:0] digIn
);
    import adsq_pkg::*;

    adsq_ctrl_s_t q;
    adsq_ctrl_s_t d;
    logic         calBusy;

    ////////////////////////////////////////////////////////////////////////
    // calibration and pin synchronisers

    adsq_calib #(
        .CAL_CYCLES (CAL_CYCLES)
    ) uCalib (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .calBusy (calBusy),
        .calEn   (calEn)
    );

    adsq_pin_sync uPinSync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pinIn   (pinIn),
        .digIn   (digIn)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers

    logic                  isCont;
    logic                  isScan;
    logic                  normDone;
    logic                  unreadNow;
    logic [`ADSQ_CH_W-1:0] firstChan;
    adsq_state_t           advSt;
    logic [`ADSQ_CH_W-1:0] advChan;

    assign isCont   = q.runMode[`ADSQ_MODE_CONT];
    assign isScan   = q.runMode[`ADSQ_MODE_SCAN];
    // last cycle of a normal conversion
    assign normDone = (q.st == ST_CONVERT) && (q.cnt == '0) && !q.isInj;
    // a read in the same cycle counts, so the old value is taken
    assign unreadNow = q.unread && !resultRead;
    // the second group only has eight channels; fold higher picks down
    assign firstChan = (portSel && startChannel >= `ADSQ_P1_CH_LIMIT)
                     ? (startChannel - `ADSQ_P1_CH_LIMIT) : startChannel;

    // where the sequence goes after a stored result
    always_comb begin
        advSt   = ST_IDLE;
        advChan = q.chan;
        if (isScan && q.chan != '0) begin
            advSt   = ST_ARM;
            advChan = q.chan - 1'b1;
        end else if (isCont && !q.stopPend) begin
            advSt   = ST_ARM;
            advChan = q.startChan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        d        = q;
        d.resEvt = 1'b0;
        d.ovrIrq = 1'b0;
        d.injEvt = 1'b0;
        // read of the result register; a buffered value moves up
        if (resultRead) begin
            if (q.tempFull) begin
                d.result   = q.temp;
                d.resChan  = q.tempChan;
                d.tempFull = 1'b0;
                d.unread   = 1'b1;
                d.resEvt   = 1'b1;
            end else begin
                d.unread = 1'b0;
            end
        end
        if (stopReq) begin
            d.stopPend = 1'b1;
        end
        unique case (q.st)
            ST_CAL: begin
                if (!calBusy) begin
                    d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                d.injPend = 1'b0;
                if (startReq) begin
                    d.runMode   = mode;
                    d.portSel   = portSel;
                    d.startChan = firstChan;
                    d.chan      = firstChan;
                    d.stopPend  = 1'b0;
                    d.st        = ST_ARM;
                end
            end
            ST_ARM: begin
                if (q.injPend) begin
                    // injection bypasses protect, it has its own register
                    d.isInj   = 1'b1;
                    d.injPend = 1'b0;
                    d.cnt     = sampleTime;
                    d.st      = ST_SAMPLE;
                end else if (!(overrunProtect && unreadNow)) begin
                    d.cnt = sampleTime;
                    d.st  = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (q.cnt == '0) begin
                    d.cnt = convTime;
                    d.st  = ST_CONVERT;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_CONVERT: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 1'b1;
                end else if (q.isInj) begin
                    d.injRes = coreData;
                    d.injEvt = 1'b1;
                    d.isInj  = 1'b0;
                    d.st     = ST_ARM;
                end else if (unreadNow && waitForReadEnable && isCont) begin
                    d.temp     = coreData;
                    d.tempChan = q.chan;
                    d.tempFull = 1'b1;
                    d.st       = ST_HOLD;
                end else begin
                    // set beats a read landing in the same cycle
                    d.ovrIrq  = unreadNow && !overrunProtect;
                    d.result  = coreData;
                    d.resChan = q.chan;
                    d.unread  = 1'b1;
                    d.resEvt  = 1'b1;
                    d.st      = advSt;
                    d.chan    = advChan;
                end
            end
            ST_HOLD: begin
                if (resultRead) begin
                    d.st   = advSt;
                    d.chan = advChan;
                end
            end
        endcase
        // injection only runs in continuous modes; it sits after the case
        // so a new request wins over the arm state taking the old one
        if (injectReq && isCont && q.st != ST_IDLE && q.st != ST_CAL) begin
            d.injPend = 1'b1;
            d.injChan = injectChannel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q         <= '0;
            q.st      <= ST_CAL;
            q.runMode <= MODE_SINGLE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign resultValue    = q.result;
    assign resultChannel  = q.resChan;
    assign resultValid    = q.unread;
    assign resultEvent    = q.resEvt;
    assign overrunIrq     = q.ovrIrq;
    assign injResultValue = q.injRes;
    assign injEvent       = q.injEvt;
    // busy covers calibration and any running sequence
    assign busyFlag       = calBusy || (q.st != ST_IDLE);
    assign muxChannel     = q.isInj ? q.injChan : q.chan;
    assign muxPortSel     = q.portSel;
    assign sampleEn       = (q.st == ST_SAMPLE);
    assign convEn         = (q.st == ST_CONVERT);

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [`ADSQ_TIME_W:0] sampCycles;

    // counts cycles spent sampling, only for the timing check
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !sampleEn) begin
            sampCycles <= '0;
        end else begin
            sampCycles <= sampCycles + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    busy_cal_a: assert property (calBusy
        |-> busyFlag && !sampleEn && !convEn)
        else $error("conversion activity during calibration");
    group_range_a: assert property (sampleEn && q.portSel && !q.isInj
        |-> muxChannel < `ADSQ_P1_CH_LIMIT)
        else $error("second group channel out of range");
    sample_len_a: assert property ($fell(sampleEn)
        |-> convEn
            && $past(sampCycles) == {1'b0, sampleTime})
        else $error("sample phase length wrong");
    overrun_pulse_a: assert property (overrunIrq
        |-> resultEvent && resultValid)
        else $error("overrun without a new stored result");
    protect_hold_a: assert property (q.st == ST_ARM && !q.injPend
        && overrunProtect && unreadNow |=> !sampleEn)
        else $error("conversion started over an unread result");
    hold_stay_a: assert property (q.st == ST_HOLD && !resultRead
        |=> q.st == ST_HOLD && resultValue == $past(resultValue))
        else $error("held result released without a read");
    inj_store_a: assert property (injEvent
        |-> injResultValue == $past(coreData)
            && resultValue == $past(resultValue))
        else $error("injected result went to the wrong register");
    inj_resume_a: assert property (injEvent
        |-> q.st == ST_ARM && q.runMode == $past(q.runMode))
        else $error("continuous mode changed by injection");
    read_clear_a: assert property (resultRead && !q.tempFull
        && !normDone |=> !resultValid)
        else $error("read did not clear the unread mark");
    scan_step_a: assert property (normDone && isScan && q.chan != '0
        && !(unreadNow && waitForReadEnable && isCont)
        |=> resultEvent && q.chan == $past(q.chan) - 1'b1)
        else $error("scan did not step to the next channel");

    scan_cont_c: cover property (resultEvent && q.runMode == MODE_SCAN_CONT);
    hold_c: cover property (q.st == ST_HOLD ##[1:40] resultRead);
    inj_c: cover property (injEvent && isCont);
    overrun_c: cover property (overrunIrq);
endmodule

// ==== hdl/adsq_pin_sync.sv ====
`timescale 1ns/10ps
`include "adsq_regs.svh"

module adsq_pin_sync (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // raw pins and synchronised digital view
    input  wire logic [`ADSQ_PIN_W-1:0] pinIn,
    output logic      [`ADSQ_PIN_W-1:0] digIn
);
    import adsq_pkg::*;

    adsq_sync_s_t q;
    adsq_sync_s_t d;

    // two stages; the first stage feeds only the second
    always_comb begin
        d    = q;
        d.s1 = pinIn;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign digIn = q.s2;
endmodule

// ==== hdl/adsq_pkg.sv ====
`include "adsq_regs.svh"

package adsq_pkg;

    // conversion modes
    typedef enum logic [1:0] {
        MODE_SINGLE    = 2'h0,
        MODE_CONT      = 2'h1,
        MODE_SCAN      = 2'h2,
        MODE_SCAN_CONT = 2'h3
    } adsq_mode_t;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_CAL     = 6'h01,
        ST_IDLE    = 6'h02,
        ST_ARM     = 6'h04,
        ST_SAMPLE  = 6'h08,
        ST_CONVERT = 6'h10,
        ST_HOLD    = 6'h20
    } adsq_state_t;

    typedef struct packed {
        adsq_state_t                st;
        logic [`ADSQ_TIME_W-1:0]    cnt;
        adsq_mode_t                 runMode;
        logic                       portSel;
        logic [`ADSQ_CH_W-1:0]      chan;
        logic [`ADSQ_CH_W-1:0]      startChan;
        logic                       isInj;
        logic                       injPend;
        logic [`ADSQ_CH_W-1:0]      injChan;
        logic                       stopPend;
        logic [`ADSQ_RES_W-1:0]     result;
        logic [`ADSQ_CH_W-1:0]      resChan;
        logic                       unread;
        logic [`ADSQ_RES_W-1:0]     temp;
        logic [`ADSQ_CH_W-1:0]      tempChan;
        logic                       tempFull;
        logic                       resEvt;
        logic                       ovrIrq;
        logic [`ADSQ_RES_W-1:0]     injRes;
        logic                       injEvt;
    } adsq_ctrl_s_t;

    typedef struct packed {
        logic [`ADSQ_CAL_CNT_W-1:0] cnt;
        logic                       busy;
    } adsq_cal_s_t;

    typedef struct packed {
        logic [`ADSQ_PIN_W-1:0]     s1;
        logic [`ADSQ_PIN_W-1:0]     s2;
    } adsq_sync_s_t;

endpackage

// ==== hdl/adsq_regs.svh ====
`ifndef ADSQ_REGS_SVH
`define ADSQ_REGS_SVH

// result width and channel select width
`define ADSQ_RES_W        10
`define ADSQ_CH_W         4
// second port group holds only the low channels
`define ADSQ_P1_CH_LIMIT  4'h8
// analog capable pins of both port groups, 16 + 8
`define ADSQ_PIN_W        24
// sample and conversion phase counters
`define ADSQ_TIME_W       8
// calibration length, given directly in cpu clock cycles
`define ADSQ_CAL_CPU_CYC  40630
`define ADSQ_CAL_CNT_W    16
// mode field: bit 0 continuous, bit 1 scan
`define ADSQ_MODE_CONT    0
`define ADSQ_MODE_SCAN    1
// reset values
`define ADSQ_RST_RES      10'h000
`define ADSQ_RST_CH       4'h0
`define ADSQ_RST_TIME     8'h00

`endif

// ==== verification/adsq_core_model.sv ====
`timescale 1ns/10ps
`include "adsq_regs.svh"

module adsq_core_model (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // multiplexer selection and conversion strobe
    input  wire logic [`ADSQ_CH_W-1:0]  muxChannel,
    input  wire logic                   muxPortSel,
    input  wire logic                   convEn,
    // conversion core data
    output logic      [`ADSQ_RES_W-1:0] coreData
);
    logic [`ADSQ_RES_W-1:0] lastQ;

    ////////////////////////////////////////////////////////////////////////
    // code tied to port and channel so every input reads differently
    assign coreData = convEn ? {muxPortSel, 1'b1, muxChannel, 4'h5} : ~lastQ;

    ////////////////////////////////////////////////////////////////////////
    // outside a conversion the bus is not driven: it flips every cycle,
    // so a design that samples one cycle late never sees a plausible code
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lastQ <= 10'h000;
        end else begin
            lastQ <= coreData;
        end
    end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`include "adsq_regs.svh"

module testbench;
    import adsq_pkg::*;
    localparam int CAL  = 20;
    localparam int WDOG = 5000;
    logic                    ref_clk = 1'b0;
    logic                    sys_rst = 1'b1;
    adsq_mode_t              mode    = MODE_SINGLE;
    logic                    portSel = 1'b0, overrunProtect = 1'b0;
    logic                    waitForReadEnable = 1'b0;
    logic                    startReq = 1'b0, stopReq = 1'b0;
    logic                    injectReq = 1'b0, resultRead = 1'b0;
    logic [`ADSQ_CH_W-1:0]   startChannel = 4'h0, injectChannel = 4'h0;
    logic [`ADSQ_TIME_W-1:0] sampleTime = 8'h01, convTime = 8'h01;
    logic [`ADSQ_PIN_W-1:0]  pinIn = 24'h00_0000;
    logic [`ADSQ_RES_W-1:0]  resultValue, injResultValue, coreData;
    logic [`ADSQ_CH_W-1:0]   resultChannel, muxChannel;
    logic [`ADSQ_PIN_W-1:0]  digIn;
    logic                    resultValid, resultEvent, overrunIrq, injEvent;
    logic                    busyFlag, muxPortSel, sampleEn, convEn, calEn;
    int                      num_errors = 0;
    int                      check_count = 0;

    adsq_ctrl #(.CAL_CYCLES(CAL)) u_adsq_ctrl (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mode(mode),
        .portSel(portSel), .startChannel(startChannel),
        .sampleTime(sampleTime), .convTime(convTime),
        .overrunProtect(overrunProtect),
        .waitForReadEnable(waitForReadEnable), .startReq(startReq),
        .stopReq(stopReq), .injectReq(injectReq),
        .injectChannel(injectChannel), .resultRead(resultRead),
        .resultValue(resultValue), .resultChannel(resultChannel),
        .resultValid(resultValid), .resultEvent(resultEvent),
        .overrunIrq(overrunIrq), .injResultValue(injResultValue),
        .injEvent(injEvent), .busyFlag(busyFlag),
        .muxChannel(muxChannel), .muxPortSel(muxPortSel),
        .sampleEn(sampleEn), .convEn(convEn), .calEn(calEn),
        .coreData(coreData), .pinIn(pinIn), .digIn(digIn));

    adsq_core_model u_adsq_core_model (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .muxChannel(muxChannel),
        .muxPortSel(muxPortSel), .convEn(convEn), .coreData(coreData));

    ////////////////////////////////////////////////////////////////////////
    // clock at 40 MHz
    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [9:0] expv(input logic p, input logic [3:0] c);
        expv = {p, 1'b1, c, 4'h5};
    endfunction

    // 0 sample phase, 1 result event, 2 injection event, else idle
    function automatic logic sel(input int k);
        case (k)
            0: sel = sampleEn;
            1: sel = resultEvent;
            2: sel = injEvent;
            default: sel = ~busyFlag;
        endcase
    endfunction

    task automatic chk(input logic [23:0] got, exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // 0 start, 1 stop, 2 inject, else result read
    task automatic drive(input int k, input logic v);
        case (k)
            0: startReq <= v;
            1: stopReq <= v;
            2: injectReq <= v;
            default: resultRead <= v;
        endcase
    endtask

    // one-cycle request; the next call waits an edge, so no double drive
    task automatic pulse(input int k);
        @(posedge ref_clk);
        drive(k, 1'b1);
        @(posedge ref_clk);
        drive(k, 1'b0);
    endtask

    // bounded wait, judged at the falling edge where outputs are settled
    task automatic wait_on(input int k, input int lim);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (sel(k) !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        chk(sel(k), 1'b1, "wait timed out");
    endtask

    task automatic setup(input adsq_mode_t m, input logic p,
                         input logic [3:0] c, input logic [7:0] st, ct);
        @(posedge ref_clk);
        mode <= m;
        portSel <= p;
        startChannel <= c;
        sampleTime <= st;
        convTime <= ct;
    endtask

    // ends any running sequence and leaves no unread result behind
    task automatic tidy(input string name);
        @(posedge ref_clk);
        overrunProtect <= 1'b0;
        waitForReadEnable <= 1'b0;
        pulse(1);
        wait_on(3, 60);
        pulse(3);
        pulse(3);
        chk(calEn, 1'b0, "calibration rerun");
        $display("test %s done", name);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_cal();
        int n;
        n = 0;
        @(negedge ref_clk);
        chk({busyFlag, calEn}, 2'h3, "busy in calibration");
        pulse(0);
        while (busyFlag === 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n > CAL - 6 && n <= CAL + 2, 1'b1, "cal length");
        n = 0;
        repeat (12) begin
            @(negedge ref_clk);
            n += sampleEn;
        end
        chk(n, 0, "early start taken");
        $display("test calibration done");
    endtask

    task automatic t_single(input logic p, input logic [3:0] c, ec,
                            input logic [7:0] st, ct);
        int ns, nc;
        ns = 0;
        nc = 0;
        setup(MODE_SINGLE, p, c, st, ct);
        pulse(0);
        wait_on(0, 8);
        while (sampleEn === 1'b1 && ns < 300) begin
            ns++;
            @(negedge ref_clk);
        end
        while (convEn === 1'b1 && nc < 300) begin
            nc++;
            @(negedge ref_clk);
        end
        chk(ns, st + 24'h1, "sample cycles");
        chk(nc, ct + 24'h1, "conversion cycles");
        chk({resultEvent, busyFlag}, 2'h2, "single done");
        chk(resultValue, expv(p, ec), "single value");
        chk(resultChannel, ec, "single channel");
        pulse(3);
        @(negedge ref_clk);
        chk(resultValid, 1'b0, "read clears");
        $display("test single done");
    endtask

    task automatic t_scan(input adsq_mode_t m, input logic [3:0] s, int n);
        logic [3:0] c;
        c = s;
        setup(m, 1'b0, s, 8'h01, 8'h01);
        pulse(0);
        for (int i = 0; i < n; i++) begin
            wait_on(1, 40);
            chk(resultChannel, c, "scan order");
            chk(resultValue, expv(1'b0, c), "scan value");
            pulse(3);
            c = (c == 4'h0) ? s : c - 4'h1;
        end
        if (m == MODE_SCAN) begin
            wait_on(3, 20);
        end
        tidy("scan");
    endtask

    task automatic t_ovr();
        setup(MODE_CONT, 1'b0, 4'h6, 8'h01, 8'h00);
        pulse(0);
        wait_on(1, 20);
        chk(overrunIrq, 1'b0, "no overrun first");
        wait_on(1, 20);
        chk(overrunIrq, 1'b1, "overrun");
        chk(resultValue, expv(1'b0, 4'h6), "repeat value");
        tidy("overrun");
    endtask

    task automatic t_prot(input logic w);
        int n, e;
        n = 0;
        e = 0;
        setup(MODE_CONT, 1'b0, 4'h7, 8'h01, 8'h01);
        overrunProtect <= ~w;
        waitForReadEnable <= w;
        pulse(0);
        wait_on(1, 20);
        repeat (30) begin
            @(negedge ref_clk);
            n += sampleEn;
            e += resultEvent + overrunIrq;
        end
        chk(e, 0, "held result lost");
        chk(w ? sampleEn : 24'(n), 24'h0, "conversion held");
        pulse(3);
        if (w) begin
            @(negedge ref_clk);
            chk({resultEvent, resultValid}, 2'h3, "buffer up");
            chk(resultValue, expv(1'b0, 4'h7), "held value");
        end else begin
            wait_on(0, 6);
        end
        tidy(w ? "wait for read" : "protect");
    endtask

    task automatic t_inj();
        setup(MODE_CONT, 1'b0, 4'h4, 8'h01, 8'h01);
        injectChannel <= 4'h9;
        pulse(0);
        wait_on(1, 20);
        pulse(2);
        wait_on(2, 30);
        chk(injResultValue, expv(1'b0, 4'h9), "injected value");
        chk(resultChannel, 4'h4, "normal result kept");
        wait_on(1, 30);
        chk(resultChannel, 4'h4, "mode resumes");
        chk(resultValue, expv(1'b0, 4'h4), "resume value");
        tidy("injection");
    endtask

    task automatic t_pins();
        @(posedge ref_clk);
        pinIn <= 24'hA5_C3F0;
        repeat (2) @(negedge ref_clk);
        chk(digIn, 24'h00_0000, "one stage only");
        @(negedge ref_clk);
        chk(digIn, 24'hA5_C3F0, "digital view");
        @(posedge ref_clk);
        pinIn <= 24'h5A_3C0F;
        repeat (3) @(negedge ref_clk);
        chk(digIn, 24'h5A_3C0F, "digital view");
        $display("test pins done");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset for 8 cycles, then every scenario in turn
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_cal();
        t_single(1'b0, 4'h5, 4'h5, 8'h03, 8'h02);
        t_single(1'b1, 4'hB, 4'h3, 8'h00, 8'h01);
        t_scan(MODE_SCAN, 4'h2, 3);
        t_scan(MODE_SCAN_CONT, 4'h1, 4);
        t_ovr();
        t_prot(1'b0);
        t_prot(1'b1);
        t_inj();
        t_pins();
        stop_test();
    end

    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        #(25 * WDOG);
        num_errors++;
        stop_test();
    end
endmodule
